/* pkg/rcc_regs.svh */
// Register map, field positions and constants of the command classifier.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

// Register offsets on the plain register port
`define RCC_ADDR_W          8
`define RCC_DATA_W          16
`define RCC_OFS_CFG         8'h00
`define RCC_OFS_IRQ         8'h01
`define RCC_OFS_LAST_CMD    8'h02
`define RCC_OFS_TBL_ADDR    8'h03
`define RCC_OFS_TBL_DATA    8'h04
`define RCC_OFS_STATUS      8'h05

// Configuration register fields
`define RCC_CFG_BCST_INV    0
`define RCC_CFG_UMC_INV     1
`define RCC_CFG_RESET       16'h0000

// Interrupt register fields; bits 2..0 are reserved
`define RCC_IRQ_BCST        5
`define RCC_IRQ_MERR        4
`define RCC_IRQ_ACCESS      3
`define RCC_IRQ_RESET       3'h0

// Status register fields
`define RCC_ST_CLEARING     0
`define RCC_ST_TA_LSB       8

// Command word fields
`define RCC_TA_MSB          15
`define RCC_TA_LSB          11
`define RCC_DIR_BIT         10
`define RCC_SA_MSB          9
`define RCC_SA_LSB          5
`define RCC_CNT_MSB         4
`define RCC_CNT_LSB         0

// Field values
`define RCC_BCST_ADDR       5'h1F
`define RCC_SA_MODE_LO      5'h00
`define RCC_SA_MODE_HI      5'h1F
`define RCC_MC_DATA_MIN     5'h10
`define RCC_MC_NODATA_MAX   5'h0F
`define RCC_MC16            5'h10
`define RCC_MC17            5'h11
`define RCC_MC18            5'h12
`define RCC_MC19            5'h13
`define RCC_MC20            5'h14
`define RCC_MC21            5'h15
`define RCC_CNT_ZERO        5'h00
`define RCC_WORDS_MAX       6'h20
`define RCC_WORDS_ONE       6'h01
`define RCC_WORDS_NONE      6'h00

// Illegal-command table
`define RCC_TBL_DEPTH       256
`define RCC_TBL_AW          8
`define RCC_TBL_LAST        8'hFF
`define RCC_TBL_CLEAR       16'h0000

`endif

/* pkg/rcc_pkg.sv */
// Types shared by the command classifier and its helper modules.
// Assumes rcc_regs.svh is on the include path.
package rcc_pkg;
    `include "rcc_regs.svh"

    // One word from the Manchester decoder, with its checks
    typedef struct packed {
        logic        strobe;
        logic        sync_is_cmd;
        logic        sync_ok;
        logic        manchester_ok;
        logic        bit_count_ok;
        logic [15:0] data;
        logic        parity;
    } rcc_rx_word_t;

    // Classified command handed to the response logic
    typedef struct packed {
        logic       accept;
        logic       broadcast;
        logic       is_mode;
        logic       dir_tx;
        logic [4:0] subaddr_field;
        logic [4:0] code;
        logic       undefined;
        logic       illegal;
        logic       send_status;
        logic [5:0] tx_words;
        logic [5:0] rx_words;
    } rcc_cmd_resp_t;

    typedef enum logic [0:0] {
        RCC_CLEARING,
        RCC_RUN
    } rcc_state_t;
endpackage : rcc_pkg

/* rtl/rcc_sync2.sv */
// Two-flop synchroniser for pin inputs of any width.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module rcc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] rst_val,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= rst_val;
            q      <= rst_val;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : rcc_sync2

/* rtl/rcc_word_check.sv */
// Word validity check: sync, Manchester, bit count and odd parity.
// Assumes the decoder delivers each word as a one-cycle strobe on core_clk.
`timescale 1ns/1ps
module rcc_word_check
    import rcc_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire rcc_rx_word_t rx_word,
    output logic              cmd_valid,
    output logic              data_valid,
    output logic [15:0]       word
);
    logic good;

    // Parity over sixteen data bits plus parity bit must be odd
    assign good = rx_word.sync_ok && rx_word.manchester_ok && rx_word.bit_count_ok
                  && (^{rx_word.data, rx_word.parity});

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_valid  <= 1'b0;
            data_valid <= 1'b0;
        end else if (ce) begin
            cmd_valid  <= rx_word.strobe && good && rx_word.sync_is_cmd;
            data_valid <= rx_word.strobe && good && !rx_word.sync_is_cmd;
        end
    end

    // Sync and parity are dropped; only the data bits go on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            word <= 16'h0000;
        end else if (ce && rx_word.strobe && good) begin
            word <= rx_word.data;
        end
    end
endmodule : rcc_word_check

/* rtl/rcc_command_classifier.sv */
// Remote terminal command classifier: validates, addresses and classifies commands.
// Assumes a same-clock word decoder and a plain register master.
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_command_classifier
    import rcc_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     ce,
    input  wire logic                     master_reset_n,
    input  wire logic [4:0]               term_addr_pin,
    input  wire rcc_pkg::rcc_rx_word_t    rx_word,
    input  wire logic                     access_notify_enable,
    input  wire logic                     msg_error_evt,
    input  wire logic [`RCC_ADDR_W-1:0]   reg_addr,
    input  wire logic [`RCC_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [`RCC_DATA_W-1:0]        reg_rdata,
    output rcc_pkg::rcc_cmd_resp_t        cmd_resp,
    output logic                          status_update,
    output logic                          data_word_strobe,
    output logic [15:0]                   data_word,
    output logic                          table_ready
);
    import rcc_pkg::*;

    localparam logic [15:0] CFG_RST_VAL = `RCC_CFG_RESET;

    // Pin inputs
    logic [4:0]  term_addr;
    logic        mr_n;

    rcc_sync2 #(.W(5)) u_ta_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .ce       (ce),
        .rst_val  (5'h00),
        .d        (term_addr_pin),
        .q        (term_addr)
    );

    rcc_sync2 #(.W(1)) u_mr_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .ce       (ce),
        .rst_val  (1'b1),
        .d        (master_reset_n),
        .q        (mr_n)
    );

    // Word checking
    logic        cw_valid;
    logic        dw_valid;
    logic [15:0] cw;

    rcc_word_check u_check (
        .core_clk   (core_clk),
        .srst       (srst),
        .ce         (ce),
        .rx_word    (rx_word),
        .cmd_valid  (cw_valid),
        .data_valid (dw_valid),
        .word       (cw)
    );

    // Registers
    logic                   bcst_inv_q;
    logic                   umc_inv_q;
    logic                   irq_bcst_q;
    logic                   irq_merr_q;
    logic                   irq_access_q;
    logic [15:0]            last_cmd_q;
    logic [`RCC_TBL_AW-1:0] tbl_addr_q;
    logic [15:0]            tbl_mem [`RCC_TBL_DEPTH];
    rcc_state_t             state_q;
    logic [`RCC_TBL_AW-1:0] clr_idx_q;

    logic wr_cfg;
    logic wr_irq;
    logic wr_tbl_addr;
    logic wr_tbl_data;

    assign wr_cfg      = reg_wr && (reg_addr == `RCC_OFS_CFG);
    assign wr_irq      = reg_wr && (reg_addr == `RCC_OFS_IRQ);
    assign wr_tbl_addr = reg_wr && (reg_addr == `RCC_OFS_TBL_ADDR);
    assign wr_tbl_data = reg_wr && (reg_addr == `RCC_OFS_TBL_DATA);

    // Command fields
    logic [4:0] f_ta;
    logic       f_dir;
    logic [4:0] f_sa;
    logic [4:0] f_cnt;

    assign f_ta  = cw[`RCC_TA_MSB:`RCC_TA_LSB];
    assign f_dir = cw[`RCC_DIR_BIT];
    assign f_sa  = cw[`RCC_SA_MSB:`RCC_SA_LSB];
    assign f_cnt = cw[`RCC_CNT_MSB:`RCC_CNT_LSB];

    // Classification
    logic       is_bcst;
    logic       is_mine;
    logic       is_mode;
    logic       is_undef;
    logic       accept;
    logic       illegal;
    logic [5:0] tx_words;
    logic [5:0] rx_words;
    logic [5:0] sa_words;
    logic [5:0] mode_words;
    logic [`RCC_TBL_AW-1:0] tbl_idx;

    assign is_bcst = (f_ta == `RCC_BCST_ADDR) && !bcst_inv_q;
    assign is_mine = (f_ta == term_addr) && (f_ta != `RCC_BCST_ADDR);
    assign is_mode = (f_sa == `RCC_SA_MODE_LO) || (f_sa == `RCC_SA_MODE_HI);

    always_comb begin
        is_undef = 1'b0;
        if (is_mode) begin
            if (!f_dir) begin
                is_undef = (f_cnt <= `RCC_MC_NODATA_MAX) || (f_cnt == `RCC_MC16)
                           || (f_cnt == `RCC_MC18) || (f_cnt == `RCC_MC19);
            end else begin
                is_undef = (f_cnt == `RCC_MC17) || (f_cnt == `RCC_MC20)
                           || (f_cnt == `RCC_MC21);
            end
        end
    end

    // Undefined mode commands are dropped only when configured invalid
    assign accept = cw_valid && (is_bcst || is_mine)
                    && !(is_undef && umc_inv_q) && (state_q == RCC_RUN) && mr_n;

    // Word address from broadcast, direction, subaddress and code MSB; bit from code LSBs
    assign tbl_idx = {is_bcst, f_dir, f_sa, f_cnt[4]};
    assign illegal = tbl_mem[tbl_idx][f_cnt[3:0]];

    assign sa_words   = (f_cnt == `RCC_CNT_ZERO) ? `RCC_WORDS_MAX : {1'b0, f_cnt};
    assign mode_words = (f_cnt >= `RCC_MC_DATA_MIN) ? `RCC_WORDS_ONE : `RCC_WORDS_NONE;

    always_comb begin
        tx_words = `RCC_WORDS_NONE;
        rx_words = `RCC_WORDS_NONE;
        if (is_mode) begin
            if (f_dir) begin
                tx_words = illegal ? `RCC_WORDS_NONE : mode_words;
            end else begin
                rx_words = mode_words;
            end
        end else begin
            if (f_dir) begin
                tx_words = illegal ? `RCC_WORDS_NONE : sa_words;
            end else begin
                rx_words = sa_words;
            end
        end
    end

    // Command response; outputs are flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_resp      <= '0;
            status_update <= 1'b0;
        end else if (ce) begin
            cmd_resp.accept        <= accept;
            cmd_resp.broadcast     <= is_bcst;
            cmd_resp.is_mode       <= is_mode;
            cmd_resp.dir_tx        <= f_dir;
            cmd_resp.subaddr_field <= f_sa;
            cmd_resp.code          <= f_cnt;
            cmd_resp.undefined     <= is_undef;
            cmd_resp.illegal       <= illegal;
            cmd_resp.send_status   <= !is_bcst;
            cmd_resp.tx_words      <= tx_words;
            cmd_resp.rx_words      <= rx_words;
            status_update          <= accept;
        end
    end

    // Data words pass straight through
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_word_strobe <= 1'b0;
            data_word        <= 16'h0000;
        end else if (ce) begin
            data_word_strobe <= dw_valid;
            if (dw_valid) begin
                data_word <= cw;
            end
        end
    end

    // Last accepted command word, for software
    always_ff @(posedge core_clk) begin
        if (srst) begin
            last_cmd_q <= 16'h0000;
        end else if (ce && accept) begin
            last_cmd_q <= cw;
        end
    end

    // Configuration bits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bcst_inv_q <= CFG_RST_VAL[`RCC_CFG_BCST_INV];
            umc_inv_q  <= CFG_RST_VAL[`RCC_CFG_UMC_INV];
        end else if (ce && wr_cfg) begin
            bcst_inv_q <= reg_wdata[`RCC_CFG_BCST_INV];
            umc_inv_q  <= reg_wdata[`RCC_CFG_UMC_INV];
        end
    end

    // Sticky interrupt flags; write one to clear, a new event wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            {irq_bcst_q, irq_merr_q, irq_access_q} <= `RCC_IRQ_RESET;
        end else if (ce) begin
            irq_bcst_q   <= (accept && is_bcst)
                            || (irq_bcst_q && !(wr_irq && reg_wdata[`RCC_IRQ_BCST]));
            irq_merr_q   <= msg_error_evt
                            || (irq_merr_q && !(wr_irq && reg_wdata[`RCC_IRQ_MERR]));
            irq_access_q <= (accept && access_notify_enable)
                            || (irq_access_q && !(wr_irq && reg_wdata[`RCC_IRQ_ACCESS]));
        end
    end

    // Table pointer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tbl_addr_q <= '0;
        end else if (ce && wr_tbl_addr) begin
            tbl_addr_q <= reg_wdata[`RCC_TBL_AW-1:0];
        end
    end

    // Clear sequencer: after reset or master reset, zero every table word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q   <= RCC_CLEARING;
            clr_idx_q <= '0;
        end else if (ce) begin
            case (state_q)
                RCC_CLEARING: begin
                    clr_idx_q <= clr_idx_q + 1'b1;
                    if (clr_idx_q == `RCC_TBL_LAST && mr_n) begin
                        state_q <= RCC_RUN;
                    end
                end
                RCC_RUN: begin
                    clr_idx_q <= '0;
                    if (!mr_n) begin
                        state_q <= RCC_CLEARING;
                    end
                end
                default: begin
                    state_q <= RCC_CLEARING;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (state_q == RCC_CLEARING) begin
                tbl_mem[clr_idx_q] <= `RCC_TBL_CLEAR;
            end else if (wr_tbl_data) begin
                tbl_mem[tbl_addr_q] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            table_ready <= 1'b0;
        end else if (ce) begin
            table_ready <= (state_q == RCC_RUN) && mr_n;
        end
    end

    // Register read, data in the following cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    `RCC_OFS_CFG: begin
                        reg_rdata[`RCC_CFG_BCST_INV] <= bcst_inv_q;
                        reg_rdata[`RCC_CFG_UMC_INV]  <= umc_inv_q;
                    end
                    `RCC_OFS_IRQ: begin
                        reg_rdata[`RCC_IRQ_BCST]   <= irq_bcst_q;
                        reg_rdata[`RCC_IRQ_MERR]   <= irq_merr_q;
                        reg_rdata[`RCC_IRQ_ACCESS] <= irq_access_q;
                    end
                    `RCC_OFS_LAST_CMD: begin
                        reg_rdata <= last_cmd_q;
                    end
                    `RCC_OFS_TBL_ADDR: begin
                        reg_rdata[`RCC_TBL_AW-1:0] <= tbl_addr_q;
                    end
                    `RCC_OFS_TBL_DATA: begin
                        reg_rdata <= tbl_mem[tbl_addr_q];
                    end
                    `RCC_OFS_STATUS: begin
                        reg_rdata[`RCC_ST_CLEARING] <= (state_q == RCC_CLEARING);
                        reg_rdata[`RCC_ST_TA_LSB +: 5] <= term_addr;
                    end
                    default: begin
                        reg_rdata <= '0;
                    end
                endcase
            end
        end
    end
endmodule : rcc_command_classifier

/* dv/rcc_bc_model.sv */
// Bus controller stand-in that hands decoded words to the classifier.
// Assumes words are taken as one-cycle strobes on core_clk.
`timescale 1ns/1ps
module rcc_bc_model
    import rcc_pkg::*;
(
    input  wire logic            core_clk,
    output rcc_pkg::rcc_rx_word_t rx_word
);
    initial rx_word = '0;

    // Bad: bit0 sync, bit1 Manchester, bit2 bit count, bit3 parity
    task automatic send(input logic [3:0] bad, input logic is_cmd, input logic [15:0] d);
        @(posedge core_clk);
        rx_word.strobe        <= 1'b1;
        rx_word.sync_is_cmd   <= is_cmd;
        rx_word.sync_ok       <= !bad[0];
        rx_word.manchester_ok <= !bad[1];
        rx_word.bit_count_ok  <= !bad[2];
        rx_word.data          <= d;
        rx_word.parity        <= ~^d ^ bad[3];
        @(posedge core_clk);
        rx_word.strobe <= 1'b0;
        rx_word.data   <= ~d;
    endtask : send
endmodule : rcc_bc_model

/* dv/rcc_command_classifier_chk.sv */
// Checker on the classifier's command path.
// Assumes ce stays high while commands are checked.
`timescale 1ns/1ps
module rcc_command_classifier_chk
    import rcc_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   srst,
    input wire logic                   ce,
    input wire rcc_pkg::rcc_rx_word_t  rx_word,
    input wire rcc_pkg::rcc_cmd_resp_t cmd_resp,
    input wire logic                   table_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst || !ce);
    rcc_rx_word_t  w;
    rcc_cmd_resp_t r;
    logic          und;
    assign w = rx_word;
    assign r = cmd_resp;
    assign und = r.dir_tx ? (r.code == 5'h11 || r.code == 5'h14 || r.code == 5'h15)
                          : (r.code < 5'h14 && r.code != 5'h11);

    chk_bad_word_drop: assert property (
        w.strobe && !(w.sync_ok && w.manchester_ok && w.bit_count_ok && ^{w.data, w.parity}) |-> ##2 !r.accept)
        else $error("bad word accepted");
    chk_data_sync_drop: assert property (w.strobe && !w.sync_is_cmd |-> ##2 !r.accept)
        else $error("data word accepted");
    chk_accept_cause: assert property (
        r.accept |-> $past(w.strobe, 2) && {r.dir_tx, r.subaddr_field, r.code} == $past(w.data[10:0], 2))
        else $error("accepted fields wrong");
    chk_mode_class: assert property (r.accept |-> r.is_mode == (r.subaddr_field inside {5'h00, 5'h1F}))
        else $error("mode class wrong");
    chk_sub_count: assert property (
        r.accept && !r.is_mode && !r.illegal |->
        (r.dir_tx ? r.tx_words : r.rx_words) == (r.code == 5'h00 ? 6'h20 : {1'b0, r.code}))
        else $error("word count wrong");
    chk_mode_words: assert property (
        r.accept && r.is_mode |-> r.rx_words == {5'h00, r.code[4] && !r.dir_tx}
        && r.tx_words == {5'h00, r.code[4] && r.dir_tx && !r.illegal})
        else $error("mode word count wrong");
    chk_undef_map: assert property (r.accept && r.is_mode |-> r.undefined == und)
        else $error("undefined flag wrong");
    chk_clear_quiet: assert property (!table_ready |-> !r.accept)
        else $error("accept while clearing");

    cover property (r.accept && r.illegal);
    cover property (r.accept && r.broadcast);
    cover property (r.accept && r.is_mode && r.undefined);
endmodule : rcc_command_classifier_chk

bind rcc_command_classifier rcc_command_classifier_chk rcc_command_classifier_chk_i (
    .core_clk(core_clk), .srst(srst), .ce(ce), .rx_word(rx_word), .cmd_resp(cmd_resp),
    .table_ready(table_ready));

/* dv/tb.sv */
// Self-checking bench for the command classifier.
// Assumes rcc_bc_model supplies the received words.
`timescale 1ns/1ps
`include "rcc_regs.svh"
module tb;
    import rcc_pkg::*;
    logic          core_clk = 1'b0;
    logic          srst = 1'b1;
    logic          ce = 1'b1;
    logic          master_reset_n = 1'b1;
    logic [4:0]    term_addr_pin = 5'h05;
    logic          access_notify_enable = 1'b0;
    logic          msg_error_evt = 1'b0;
    logic [7:0]    reg_addr = 8'h00;
    logic [15:0]   reg_wdata = 16'h0000;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [15:0]   reg_rdata;
    logic [15:0]   data_word;
    logic          data_word_strobe;
    logic          status_update;
    logic          table_ready;
    logic          und;
    rcc_rx_word_t  rx_word;
    rcc_cmd_resp_t cmd_resp;
    int            fail_count = 0;
    int            num_checks = 0;

    always #2.5 core_clk = ~core_clk;

    rcc_bc_model bc_i (.core_clk(core_clk), .rx_word(rx_word));
    rcc_command_classifier rcc_command_classifier_i (
        .core_clk(core_clk), .srst(srst), .ce(ce), .master_reset_n(master_reset_n),
        .term_addr_pin(term_addr_pin), .rx_word(rx_word), .access_notify_enable(access_notify_enable),
        .msg_error_evt(msg_error_evt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_resp(cmd_resp), .status_update(status_update),
        .data_word_strobe(data_word_strobe), .data_word(data_word), .table_ready(table_ready));

    function automatic logic [15:0] cw(input logic [4:0] ta, input logic d, input logic [4:0] sa,
                                       input logic [4:0] c);
        return {ta, d, sa, c};
    endfunction : cw

    function automatic logic undef(input logic [4:0] c, input logic d);
        return d ? (c == 5'h11 || c == 5'h14 || c == 5'h15) : (c < 5'h14 && c != 5'h11);
    endfunction : undef

    task automatic end_sim;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic expect16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : expect16

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        expect16(reg_rdata, e);
    endtask : rd

    task automatic cmd(input logic [3:0] bad, input logic is_cmd, input logic [15:0] w, input logic acc);
        bc_i.send(bad, is_cmd, w);
        @(posedge core_clk);
        #1;
        expect16({14'h0000, cmd_resp.accept, status_update}, {14'h0000, acc, acc});
    endtask : cmd

    task automatic wait_ready;
        int n;
        n = 0;
        while (table_ready !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        expect16({15'h0000, table_ready}, 16'h0001);
    endtask : wait_ready

    initial begin
        #50000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        wait_ready();
        rd(`RCC_OFS_CFG, 16'h0000);
        rd(`RCC_OFS_STATUS, 16'h0500);
        wr(8'h7E, 16'hFFFF);
        rd(8'h7E, 16'h0000);
        @(posedge core_clk);
        msg_error_evt <= 1'b1;
        @(posedge core_clk);
        msg_error_evt <= 1'b0;
        wr(`RCC_OFS_IRQ, 16'h0007);
        rd(`RCC_OFS_IRQ, 16'h0010);
        wr(`RCC_OFS_IRQ, 16'hFFFF);
        access_notify_enable <= 1'b1;
        cmd(4'h0, 1'b1, cw(5'h05, 1'b1, 5'h03, 5'h00), 1'b1);
        expect16({10'h000, cmd_resp.tx_words}, 16'h0020);
        access_notify_enable <= 1'b0;
        rd(`RCC_OFS_IRQ, 16'h0008);
        wr(`RCC_OFS_IRQ, 16'h0008);
        cmd(4'h0, 1'b1, cw(5'h1F, 1'b0, 5'h1E, 5'h05), 1'b1);
        expect16({10'h000, cmd_resp.rx_words}, 16'h0005);
        expect16({14'h0000, cmd_resp.broadcast, cmd_resp.send_status}, 16'h0002);
        rd(`RCC_OFS_IRQ, 16'h0020);
        rd(`RCC_OFS_LAST_CMD, cw(5'h1F, 1'b0, 5'h1E, 5'h05));
        wr(`RCC_OFS_IRQ, 16'h0020);
        cmd(4'h0, 1'b1, cw(5'h06, 1'b1, 5'h01, 5'h01), 1'b0);
        wr(`RCC_OFS_CFG, 16'h0001);
        cmd(4'h0, 1'b1, cw(5'h1F, 1'b0, 5'h01, 5'h01), 1'b0);
        rd(`RCC_OFS_IRQ, 16'h0000);
        wr(`RCC_OFS_CFG, 16'h0000);
        ce <= 1'b0;
        cmd(4'h0, 1'b1, cw(5'h05, 1'b1, 5'h03, 5'h01), 1'b0);
        @(posedge core_clk);
        ce <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            cmd(4'h1 << i, 1'b1, cw(5'h05, 1'b1, 5'h02, 5'h04), 1'b0);
        end
        cmd(4'h0, 1'b0, cw(5'h05, 1'b1, 5'h02, 5'h01), 1'b0);
        expect16(data_word_strobe ? data_word : 16'h0000, cw(5'h05, 1'b1, 5'h02, 5'h01));
        for (int u = 0; u < 2; u++) begin
            wr(`RCC_OFS_CFG, {14'h0000, u[0], 1'b0});
            for (int k = 0; k < 64; k++) begin
                und = undef(k[4:0], k[5]);
                cmd(4'h0, 1'b1, cw(5'h05, k[5], {5{k[0]}}, k[4:0]), !(u[0] && und));
                if (u == 0) begin
                    expect16({15'h0000, cmd_resp.undefined}, {15'h0000, und});
                end
            end
        end
        wr(`RCC_OFS_CFG, 16'h0000);
        wr(`RCC_OFS_TBL_ADDR, 16'h0041);
        rd(`RCC_OFS_TBL_ADDR, 16'h0041);
        wr(`RCC_OFS_TBL_DATA, 16'h0202);
        rd(`RCC_OFS_TBL_DATA, 16'h0202);
        cmd(4'h0, 1'b1, cw(5'h05, 1'b1, 5'h00, 5'h11), 1'b1);
        expect16({cmd_resp.illegal, 9'h000, cmd_resp.tx_words}, 16'h8000);
        cmd(4'h0, 1'b1, cw(5'h05, 1'b1, 5'h00, 5'h19), 1'b1);
        expect16({15'h0000, cmd_resp.illegal}, 16'h0001);
        cmd(4'h0, 1'b1, cw(5'h05, 1'b1, 5'h00, 5'h14), 1'b1);
        expect16({cmd_resp.illegal, 9'h000, cmd_resp.tx_words}, 16'h0001);
        master_reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        master_reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(`RCC_OFS_STATUS, 16'h0501);
        wait_ready();
        wr(`RCC_OFS_TBL_ADDR, 16'h0041);
        rd(`RCC_OFS_TBL_DATA, 16'h0000);
        end_sim();
    end
endmodule : tb
